// >>> design/ctf_pkg.sv
// constants shared by the transmit buffer and acceptance filter block
package ctf_pkg;
    localparam int          TX_BUFS      = 3;           // transmit message buffers
    localparam int          TX_BYTES     = 13;          // bytes per message buffer
    localparam int          ADDR_W       = 6;           // register port address width
    localparam logic [5:0]  A_PRIO0      = 6'h30;       // local priority, buffer 0..2
    localparam logic [5:0]  A_TX_FLAG    = 6'h34;       // tx_flag_reg
    localparam logic [5:0]  A_TX_CTRL    = 6'h35;       // tx_control_reg
    localparam logic [5:0]  A_RX_FLAG    = 6'h36;       // rx_flag_reg
    localparam logic [5:0]  A_ACC_CTRL   = 6'h37;       // acceptance_control_reg
    localparam logic [5:0]  A_PAT0       = 6'h38;       // acceptance pattern 0..3
    localparam logic [5:0]  A_MASK0      = 6'h3C;       // acceptance mask 0..3
    localparam logic [7:0]  LOCAL_PRIORITY_RST     = 8'h00;       // local priority after reset
    localparam logic [2:0]  TXE_RST      = 3'h7;        // all buffers empty after reset
    localparam logic [1:0]  MODE_RST     = 2'h0;        // filter mode after reset
    // acceptance filter modes, field bits 5:4 of acceptance_control_reg
    localparam logic [1:0]  MODE_32      = 2'h0;
    localparam logic [1:0]  MODE_16      = 2'h1;
    localparam logic [1:0]  MODE_8       = 2'h2;
    localparam logic [1:0]  MODE_CLOSED  = 2'h3;
    localparam int          ACC_MODE_LSB = 4;           // mode field position
    localparam int          TX_ABORT_ACKNOWLEDGE_LSB = 4;           // abort_acknowledge in tx_flag_reg
    localparam int          TX_IE_LSB    = 4;           // interrupt enables in tx_control_reg
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,                                // no buffer on the bus
        TX_BUSY = 2'b10                                 // selected buffer being sent
    } ctf_tx_state_e;
endpackage : ctf_pkg

// >>> design/ctf_top.sv
// transmit buffers with local priority scheduling and identifier acceptance filter
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ctf_top
(
    input  wire logic                       i_clock,
    input  wire logic                       i_nrst,
    input  wire logic                       i_ce,
    input  wire logic [ctf_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [7:0]                 i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    output logic      [7:0]                 o_rdata,
    input  wire logic                       i_arb_start,
    input  wire logic                       i_tx_done,
    input  wire logic                       i_tx_fail,
    input  wire logic [3:0]                 i_tx_byte_idx,
    output logic                            o_tx_req,
    output logic      [1:0]                 o_tx_sel,
    output logic      [7:0]                 o_tx_byte,
    output logic                            o_tx_irq,
    input  wire logic                       i_rx_eof,
    input  wire logic [31:0]                i_rx_id,
    input  wire logic                       i_rx_ext,
    input  wire logic                       i_rx_stuff_1615,
    output logic                            o_rx_full
);
    import ctf_pkg::*;
    // masked compare of one byte: mask one means don't care
    function automatic logic byte_hit(input logic [7:0] id, input logic [7:0] pat,
                                      input logic [7:0] msk);
        byte_hit = ((id ^ pat) & ~msk) == 8'h00;
    endfunction : byte_hit

    // register file and transmit state
    logic [7:0]    mem_q  [TX_BUFS][TX_BYTES];   // message storage
    logic [7:0]    mem_d  [TX_BUFS][TX_BYTES];
    logic [7:0]    local_priority_q [TX_BUFS];             // local_priority per buffer
    logic [7:0]    local_priority_d [TX_BUFS];
    logic [7:0]    pat_q  [4];                   // acceptance_pattern_regs
    logic [7:0]    pat_d  [4];
    logic [7:0]    msk_q  [4];                   // acceptance_mask_regs
    logic [7:0]    msk_d  [4];
    logic [2:0]    txe_q, txe_d;                 // tx_buffer_empty_flag
    logic [2:0]    abort_acknowledge_q, abort_acknowledge_d;             // abort_acknowledge
    logic [2:0]    abort_request_q, abort_request_d;             // abort_request
    logic [2:0]    txie_q, txie_d;               // transmit interrupt enables
    logic          rxf_q, rxf_d;                 // rx_buffer_full_flag
    logic [1:0]    hit_q, hit_d;                 // filter_hit_indicator
    logic [1:0]    mode_q, mode_d;               // filter mode
    ctf_tx_state_e st_q, st_d;                   // transmit sequencer
    logic [1:0]    sel_q, sel_d;                 // buffer on the bus
    logic [7:0]    rdata_q, rdata_d;             // read data, one cycle later
    logic [7:0]    txb_q, txb_d;                 // byte handed to the engine
    logic          irq_q, irq_d;                 // transmit interrupt
    // combinational helpers
    logic [7:0]    rd_val;                       // value at the read address
    logic [3:0]    fhit;                         // per filter section match
    logic          acc_any;                      // some section matched
    logic [1:0]    acc_num;                      // lowest matching section
    logic [7:0]    id1_eff;                      // second byte as compared
    logic          best_ok;                      // some buffer ready
    logic [1:0]    best;                         // chosen buffer
    logic [2:0]    ready;                        // scheduled buffers
    logic          is_buf;                       // address hits a message buffer
    logic [1:0]    bsel;
    logic [3:0]    bidx;
    assign bsel   = i_addr[5:4];
    assign bidx   = i_addr[3:0];
    assign is_buf = (bsel != 2'h3) && (bidx < 4'(TX_BYTES));
    assign ready  = ~txe_q & ~abort_request_q; // an aborting buffer is being freed, never picked
    // buffer selection: lowest value first, ties to lowest index
    always_comb
    begin
        best_ok = 1'b0;
        best    = 2'h0;
        // strict less keeps the earlier index on a tie
        for (int b = 0; b < TX_BUFS; b++)
            if (ready[b] && (!best_ok || local_priority_q[b] < local_priority_q[best]))
            begin
                best_ok = 1'b1;
                best    = 2'(b);
            end
    end

    // defect: with a stuff bit between ID16 and ID15 the second byte is seen
    // one position early; kept on purpose so software sees the real behaviour
    always_comb
    begin
        id1_eff = i_rx_id[23:16];
        if (i_rx_ext && i_rx_stuff_1615 && (mode_q == MODE_32 || mode_q == MODE_16))
            id1_eff = {i_rx_id[24], i_rx_id[23:17]};
    end

    // filter sections per mode
    always_comb
    begin
        fhit = 4'h0;
        case (mode_q)
            MODE_32:
                fhit[0] = byte_hit(i_rx_id[31:24], pat_q[0], msk_q[0])
                        & byte_hit(id1_eff, pat_q[1], msk_q[1])
                        & byte_hit(i_rx_id[15:8], pat_q[2], msk_q[2])
                        & byte_hit(i_rx_id[7:0], pat_q[3], msk_q[3]);
            MODE_16:
            begin
                fhit[0] = byte_hit(i_rx_id[31:24], pat_q[0], msk_q[0])
                        & byte_hit(id1_eff, pat_q[1], msk_q[1]);
                fhit[1] = byte_hit(i_rx_id[31:24], pat_q[2], msk_q[2])
                        & byte_hit(id1_eff, pat_q[3], msk_q[3]);
            end
            MODE_8:
                for (int k = 0; k < 4; k++)
                    fhit[k] = byte_hit(i_rx_id[31:24], pat_q[k], msk_q[k]);
            default:
                fhit = 4'h0;
        endcase
        acc_any = |fhit;
        // priority encoder, lowest section first
        acc_num = fhit[0] ? 2'h0 : fhit[1] ? 2'h1 : fhit[2] ? 2'h2 : 2'h3;
    end

    // read multiplexer
    always_comb
    begin
        rd_val = 8'h00;
        if (is_buf)
            rd_val = mem_q[bsel][bidx];
        else if (i_addr >= A_PRIO0 && i_addr < A_PRIO0 + 6'(TX_BUFS))
            rd_val = local_priority_q[i_addr[1:0]];
        else if (i_addr == A_TX_FLAG)
            rd_val = {1'b0, abort_acknowledge_q, 1'b0, txe_q};
        else if (i_addr == A_TX_CTRL)
            rd_val = {1'b0, txie_q, 1'b0, abort_request_q};
        else if (i_addr == A_RX_FLAG)
            rd_val = {7'h00, rxf_q};
        else if (i_addr == A_ACC_CTRL)
            rd_val = {2'h0, mode_q, 2'h0, hit_q};
        else if (i_addr >= A_PAT0 && i_addr < A_MASK0)
            rd_val = pat_q[i_addr[1:0]];
        else if (i_addr >= A_MASK0)
            rd_val = msk_q[i_addr[1:0]];
    end

    // next state of everything
    always_comb
    begin
        mem_d   = mem_q;
        local_priority_d  = local_priority_q;
        pat_d   = pat_q;
        msk_d   = msk_q;
        txe_d   = txe_q;
        abort_acknowledge_d = abort_acknowledge_q;
        abort_request_d = abort_request_q;
        txie_d  = txie_q;
        rxf_d   = rxf_q;
        hit_d   = hit_q;
        mode_d  = mode_q;
        st_d    = st_q;
        sel_d   = sel_q;
        rdata_d = i_rd ? rd_val : 8'h00;
        txb_d   = (i_tx_byte_idx < 4'(TX_BYTES)) ? mem_q[sel_q][i_tx_byte_idx] : 8'h00;
        // software writes first, so hardware sets below win the same cycle
        if (i_wr)
        begin
            if (is_buf)
                mem_d[bsel][bidx] = i_wdata;
            else if (i_addr >= A_PRIO0 && i_addr < A_PRIO0 + 6'(TX_BUFS))
                local_priority_d[i_addr[1:0]] = i_wdata;
            else if (i_addr == A_TX_FLAG)
            begin
                // write one marks the buffer ready; old acknowledge goes too
                txe_d   = txe_q & ~i_wdata[2:0];
                abort_acknowledge_d = abort_acknowledge_q & ~i_wdata[2:0];
            end
            else if (i_addr == A_TX_CTRL)
            begin
                abort_request_d = (abort_request_q | i_wdata[2:0]) & ~txe_q;
                txie_d  = i_wdata[TX_IE_LSB +: 3];
            end
            else if (i_addr == A_RX_FLAG)
                rxf_d = rxf_q & ~i_wdata[0];
            else if (i_addr == A_ACC_CTRL)
                mode_d = i_wdata[ACC_MODE_LSB +: 2];
            else if (i_addr >= A_PAT0 && i_addr < A_MASK0)
                pat_d[i_addr[1:0]] = i_wdata;
            else if (i_addr >= A_MASK0)
                msk_d[i_addr[1:0]] = i_wdata;
        end
        // aborts of buffers that are not on the bus
        for (int b = 0; b < TX_BUFS; b++)
            if (abort_request_q[b] && !txe_q[b] && !(st_q == TX_BUSY && sel_q == 2'(b)))
            begin
                txe_d[b]   = 1'b1;
                abort_acknowledge_d[b] = 1'b1;
                abort_request_d[b] = 1'b0;
            end
        // transmit sequencer
        case (st_q)
            TX_IDLE:
                if (i_arb_start && best_ok)
                begin
                    st_d  = TX_BUSY;
                    sel_d = best;
                end
            TX_BUSY:
                if (i_tx_done)
                begin
                    txe_d[sel_q]   = 1'b1;
                    abort_acknowledge_d[sel_q] = 1'b0;
                    abort_request_d[sel_q] = 1'b0;
                    st_d           = TX_IDLE;
                end
                else if (i_tx_fail)
                    st_d = TX_IDLE;
            default:
                st_d = TX_IDLE;
        endcase
        // acceptance at end of frame; full foreground buffer is kept
        if (i_rx_eof && acc_any && !rxf_q)
        begin
            rxf_d = 1'b1;
            hit_d = acc_num;
        end
        irq_d = |(txe_d & txie_d);
    end

    // registers
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            for (int b = 0; b < TX_BUFS; b++)
            begin
                local_priority_q[b] <= LOCAL_PRIORITY_RST;
                for (int k = 0; k < TX_BYTES; k++)
                    mem_q[b][k] <= 8'h00;
            end
            for (int k = 0; k < 4; k++)
            begin
                pat_q[k] <= 8'h00;
                msk_q[k] <= 8'h00;
            end
            txe_q   <= TXE_RST;
            abort_acknowledge_q <= 3'h0;
            abort_request_q <= 3'h0;
            txie_q  <= 3'h0;
            rxf_q   <= 1'b0;
            hit_q   <= 2'h0;
            mode_q  <= MODE_RST;
            st_q    <= TX_IDLE;
            sel_q   <= 2'h0;
            rdata_q <= 8'h00;
            txb_q   <= 8'h00;
            irq_q   <= 1'b0;
        end
        else if (i_ce)
        begin
            mem_q   <= mem_d;
            local_priority_q  <= local_priority_d;
            pat_q   <= pat_d;
            msk_q   <= msk_d;
            txe_q   <= txe_d;
            abort_acknowledge_q <= abort_acknowledge_d;
            abort_request_q <= abort_request_d;
            txie_q  <= txie_d;
            rxf_q   <= rxf_d;
            hit_q   <= hit_d;
            mode_q  <= mode_d;
            st_q    <= st_d;
            sel_q   <= sel_d;
            rdata_q <= rdata_d;
            txb_q   <= txb_d;
            irq_q   <= irq_d;
        end
    end

    assign o_rdata   = rdata_q;
    assign o_tx_req  = st_q[1]; // one-hot busy bit, no gate after the flop
    assign o_tx_sel  = sel_q;
    assign o_tx_byte = txb_q;
    assign o_tx_irq  = irq_q;
    assign o_rx_full = rxf_q;
    // checks
    a_start_picks_best: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && st_q == TX_IDLE && i_arb_start && best_ok |=> st_q == TX_BUSY && sel_q == $past(best))
        else $error("arbitration did not pick the best buffer");
    a_done_sets_empty: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && st_q == TX_BUSY && i_tx_done |=> txe_q[$past(sel_q)] && !abort_acknowledge_q[$past(sel_q)])
        else $error("sent buffer not freed");
    a_fail_rearb: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && st_q == TX_BUSY && !i_tx_done && i_tx_fail |=> st_q == TX_IDLE)
        else $error("failed transfer did not return to arbitration");
    a_abort_ack: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && abort_request_q[0] && !txe_q[0] && (st_q == TX_IDLE || sel_q != 2'h0)
        |=> txe_q[0] && abort_acknowledge_q[0])
        else $error("idle buffer abort not acknowledged");
    a_busy_no_abort: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && st_q == TX_BUSY && !i_tx_done && !i_tx_fail |=> $stable(sel_q) && !txe_q[sel_q])
        else $error("buffer on the bus was released early");
    a_irq_follows: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce ##1 1'b1 |-> o_tx_irq == |(txe_q & txie_q))
        else $error("transmit interrupt mismatch");
    a_closed_no_full: assert property (@(posedge i_clock) disable iff (!i_nrst)
        mode_q == MODE_CLOSED && !rxf_q && !(i_wr && i_addr == A_ACC_CTRL) |=> !rxf_q)
        else $error("closed filter accepted a frame");
    a_accept_hit: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && i_rx_eof && acc_any && !rxf_q |=> rxf_q && hit_q == $past(acc_num))
        else $error("accepted frame not flagged");
    a_read_latency: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && !i_rd ##1 i_ce |-> o_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule : ctf_top
`default_nettype wire

// >>> dv/ctf_engine_model.sv
// protocol engine model: arbitration, byte fetch, frame end and received identifiers
`timescale 1ns/1ps
`default_nettype none
module ctf_engine_model
(
    input  wire logic        i_clock,
    input  wire logic        i_tx_req,
    input  wire logic [1:0]  i_tx_sel,
    input  wire logic [7:0]  i_tx_byte,
    output logic             o_arb_start,
    output logic             o_tx_done,
    output logic             o_tx_fail,
    output logic      [3:0]  o_tx_byte_idx,
    output logic             o_rx_eof,
    output logic      [31:0] o_rx_id,
    output logic             o_rx_ext,
    output logic             o_rx_stuff_1615
);
    logic [7:0] got [13];   // bytes fetched in the last frame
    logic [1:0] sel_seen;   // buffer on the bus in the last frame
    logic       req_seen;   // request seen one cycle after arbitration
    // idle levels; index parked outside the buffer
    initial
    begin
        o_arb_start     = 1'b0;
        o_tx_done       = 1'b0;
        o_tx_fail       = 1'b0;
        o_tx_byte_idx   = 4'hF;
        o_rx_eof        = 1'b0;
        o_rx_id         = 32'h0;
        o_rx_ext        = 1'b0;
        o_rx_stuff_1615 = 1'b0;
    end
    // one arbitration; a set fail ends the frame with an error, buffer stays scheduled
    task automatic send(input bit fail);
        @(posedge i_clock);
        o_arb_start <= 1'b1;
        @(posedge i_clock);
        o_arb_start <= 1'b0;
        #1 req_seen = i_tx_req;
        sel_seen = i_tx_sel;
        if (i_tx_req)
        begin
            for (int k = 0; k < 13; k++)
            begin
                @(posedge i_clock);
                o_tx_byte_idx <= 4'(k);
                @(posedge i_clock);
                #1 got[k] = i_tx_byte;
            end
            @(posedge i_clock);
            o_tx_byte_idx <= 4'hF;
            o_tx_done     <= !fail;
            o_tx_fail     <= fail;
            @(posedge i_clock);
            o_tx_done     <= 1'b0;
            o_tx_fail     <= 1'b0;
            #1;
        end
    endtask : send
    // one correctly received frame; identifier is scrambled once the pulse is over
    task automatic recv(input logic [31:0] id, input logic ext, input logic stf);
        @(posedge i_clock);
        o_rx_id         <= id;
        o_rx_ext        <= ext;
        o_rx_stuff_1615 <= stf;
        o_rx_eof        <= 1'b1;
        @(posedge i_clock);
        o_rx_eof        <= 1'b0;
        o_rx_id         <= ~id;
        o_rx_ext        <= ~ext;
        #1;
    endtask : recv
endmodule : ctf_engine_model
`default_nettype wire

// >>> dv/can_tx_buffers_id_filter_test.sv
// self-checking bench for transmit scheduling, abort and acceptance filtering
`timescale 1ns/1ps
`default_nettype none
module can_tx_buffers_id_filter_test;
    import ctf_pkg::*;
    logic        i_clock = 1'b0, i_nrst, i_ce, i_wr, i_rd;
    logic [5:0]  i_addr;
    logic [7:0]  i_wdata, o_rdata, o_tx_byte;
    logic        arb, done, fail, eof, ext, stf, o_tx_req, o_tx_irq, o_rx_full;
    logic [3:0]  idx;
    logic [1:0]  o_tx_sel;
    logic [31:0] rid;
    int          mismatches = 0, n_checks = 0, cyc = 0, sb, mode = 0, hit = 0;
    logic [2:0]  emp = 3'h7, ack = 3'h0, ie = 3'b101;   // model flags and enables
    int          local_priority [3] = '{0, 0, 0};                  // model local priorities
    logic [7:0]  bm [3][13];                             // model buffer contents
    logic [7:0]  pat [4], msk [4];                       // model filter bank
    bit          full = 1'b0;
    always #10 i_clock = ~i_clock;
    ctf_top u_ctf_top (.i_clock(i_clock), .i_nrst(i_nrst), .i_ce(i_ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_arb_start(arb),
        .i_tx_done(done), .i_tx_fail(fail), .i_tx_byte_idx(idx), .o_tx_req(o_tx_req),
        .o_tx_sel(o_tx_sel), .o_tx_byte(o_tx_byte), .o_tx_irq(o_tx_irq), .i_rx_eof(eof),
        .i_rx_id(rid), .i_rx_ext(ext), .i_rx_stuff_1615(stf), .o_rx_full(o_rx_full));
    ctf_engine_model u_ctf_engine_model (.i_clock(i_clock), .i_tx_req(o_tx_req),
        .i_tx_sel(o_tx_sel), .i_tx_byte(o_tx_byte), .o_arb_start(arb), .o_tx_done(done),
        .o_tx_fail(fail), .o_tx_byte_idx(idx), .o_rx_eof(eof), .o_rx_id(rid),
        .o_rx_ext(ext), .o_rx_stuff_1615(stf));
    // verdict, reached from the main sequence or the hang limit
    task automatic tally_and_finish();
        if (mismatches == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    // hang limit, far above the few thousand cycles the run needs
    always @(posedge i_clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // register port: one-cycle strobes, read data sampled in the cycle after
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clock);
        i_wr    <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string what);
        @(posedge i_clock);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clock);
        i_rd   <= 1'b0;
        #1 chk(o_rdata, exp, what);
    endtask : rd
    // lowest priority value among ready buffers, lowest index on a tie
    function automatic int pick();
        int b = -1;
        for (int i = 0; i < 3; i++)
            if (!emp[i] && (b < 0 || local_priority[i] < local_priority[b]))
                b = i;
        return b;
    endfunction : pick
    // fill a buffer and its priority, then mark it ready
    task automatic load(input int b);
        for (int k = 0; k < 13; k++)
        begin
            bm[b][k] = 8'($urandom);
            wr(6'(16 * b + k), bm[b][k]);
        end
        local_priority[b] = $urandom % 3;   // small range so ties are common
        wr(A_PRIO0 + 6'(b), 8'(local_priority[b]));
        rd(A_PRIO0 + 6'(b), 8'(local_priority[b]), "priority");
        wr(A_TX_FLAG, 8'(1 << b));
        emp[b] = 1'b0;
        ack[b] = 1'b0;
    endtask : load
    // one arbitration through the engine model, then flags and interrupt
    task automatic xmit(input bit fl);
        int b;
        b = pick();
        u_ctf_engine_model.send(fl);
        chk({7'h0, u_ctf_engine_model.req_seen}, {7'h0, b >= 0}, "request");
        if (b >= 0)
        begin
            chk({6'h0, u_ctf_engine_model.sel_seen}, 8'(b), "selected");
            for (int k = 0; k < 13; k++)
                chk(u_ctf_engine_model.got[k], bm[b][k], "tx byte");
            if (!fl)
            begin
                emp[b] = 1'b1;
                ack[b] = 1'b0;
            end
        end
        rd(A_TX_FLAG, {1'b0, ack, 1'b0, emp}, "tx flags");
        chk({7'h0, o_tx_irq}, {7'h0, |(emp & ie)}, "tx irq");
    endtask : xmit
    // abort all buffers while one is on the bus
    task automatic abort_run(input bit fl);
        int b;
        for (int i = 0; i < 3; i++)
            load(i);
        b = pick();
        fork
            xmit(fl);
            begin
                repeat (6) @(posedge i_clock);
                wr(A_TX_CTRL, {1'b0, ie, 1'b0, 3'h7});
                for (int i = 0; i < 3; i++)
                    if (!emp[i] && (i != b || fl))
                    begin
                        emp[i] = 1'b1;
                        ack[i] = 1'b1;
                    end
            end
        join
    endtask : abort_run
    function automatic bit ok(input logic [7:0] v, input int s);
        return ((v ^ pat[s]) & ~msk[s]) == 8'h0;
    endfunction : ok
    // lowest matching section or -1
    function automatic int fhit(input logic [31:0] id, input bit x, input bit st);
        logic [7:0] by [4];
        by = '{id[31:24], id[23:16], id[15:8], id[7:0]};
        if (x && st && mode < 2)
            by[1] = {by[0][0], by[1][7:1]};
        if (mode == 0)
            return (ok(by[0], 0) && ok(by[1], 1) && ok(by[2], 2) && ok(by[3], 3)) ? 0 : -1;
        for (int f = 0; f < 4; f++)
            if (mode == 1 && f < 2 && ok(by[0], 2 * f) && ok(by[1], 2 * f + 1))
                return f;
            else if (mode == 2 && ok(by[0], f))
                return f;
        return -1;
    endfunction : fhit
    initial
    begin
        logic [31:0] id;
        bit          x, st;
        int          h, f;
        void'($urandom(32'h1b972169));
        {i_nrst, i_wr, i_rd, i_addr, i_wdata} = '0;
        i_ce = 1'b1;
        repeat (6) @(posedge i_clock);
        i_nrst <= 1'b1;
        #1;
        rd(A_TX_FLAG, {5'h0, TXE_RST}, "reset flags");
        rd(A_TX_CTRL, 8'h00, "reset control");
        rd(A_ACC_CTRL, {2'h0, MODE_RST, 4'h0}, "reset filter control");
        rd(A_PRIO0, LOCAL_PRIORITY_RST, "reset priority");
        i_ce <= 1'b0;   // frozen: this write must not land
        wr(A_PRIO0, 8'h5A);
        i_ce <= 1'b1;
        rd(A_PRIO0, LOCAL_PRIORITY_RST, "frozen write");
        wr(6'h33, 8'hFF);
        rd(6'h33, 8'h00, "unmapped");
        wr(A_TX_CTRL, {1'b0, ie, 4'h0});   // buffer 1 interrupt masked
        repeat (6)
        begin
            for (int i = 0; i < 3; i++)
                load(i);
            xmit(1'b1);
            sb = pick();
            local_priority[sb] = 255;
            wr(A_PRIO0 + 6'(sb), 8'hFF);
            repeat (4) xmit(1'b0);
        end
        abort_run(1'b0);
        abort_run(1'b1);
        for (int m = 0; m < 4; m++)
        begin
            mode = m;
            wr(A_ACC_CTRL, 8'(m << ACC_MODE_LSB));
            for (int s = 0; s < 4; s++)
            begin
                pat[s] = 8'($urandom);
                msk[s] = 8'($urandom & $urandom);
                if (s == 1 && m < 2 && $urandom % 2)
                    msk[s] = msk[s] | 8'hF1;
                wr(A_PAT0 + 6'(s), pat[s]);
                wr(A_MASK0 + 6'(s), msk[s]);
            end
            repeat (24)
            begin
                f = $urandom % 4;
                id = {pat[f], pat[f | 1], pat[2], pat[3]} ^ ($urandom & $urandom & $urandom);
                x = $urandom;
                st = $urandom;
                h = fhit(id, x, st);
                if (!full && h >= 0)
                begin
                    full = 1'b1;
                    hit = h;
                end
                u_ctf_engine_model.recv(id, x, st);
                chk({7'h0, o_rx_full}, {7'h0, full}, "rx full");
                rd(A_ACC_CTRL, {2'h0, 2'(m), 2'h0, 2'(hit)}, "hit");
                wr(A_RX_FLAG, 8'h00);
                rd(A_RX_FLAG, {7'h0, full}, "rx flag kept");
                if ($urandom % 2)
                begin
                    wr(A_RX_FLAG, 8'h01);
                    full = 1'b0;
                end
            end
        end
        tally_and_finish();
    end
endmodule : can_tx_buffers_id_filter_test
`default_nettype wire
